// File: core/ri_reset_init.sv
`timescale 1ns/1ns
module ri_reset_init #(
    parameter bit PA6_IMPL = 1'b1
) (
    // Clock and reset.
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    // APB slave.
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Reset and wake events, one-cycle pulses.
    input  wire logic        i_por_rst,
    input  wire logic        i_bor_rst,
    input  wire logic        i_master_clear_pin_reset,
    input  wire logic        i_watchdog_timer_rst,
    input  wire logic        i_sw_rst,
    input  wire logic        i_stack_full_rst,
    input  wire logic        i_stack_unf_rst,
    input  wire logic        i_watchdog_timer_wake,
    input  wire logic        i_irq_wake,
    // Core state.
    input  wire logic        i_asleep,
    input  wire logic [7:0]  i_irq_src,
    input  wire logic        i_port_a6,
    // Outputs.
    output logic      [20:0] o_pc,
    output logic             o_long_wr_en,
    output logic             o_port_a6_o,
    output logic             o_port_a6_oe
);

    ////////////////////////////////////////////////////////////////////////////////
    logic                  rst_s1_q;
    logic                  rst_n_q;
    logic [7:0]            regs_q [ri_pkg::RI_NREG];
    logic [7:0]            reset_cause_control_q;
    logic [7:0]            reset_cause_control_d;
    logic [20:0]           pc_q;
    logic [20:0]           pc_d;
    logic [20:0]           top_q;
    logic [7:0]            sptr_q;
    logic [7:0]            sptr_d;
    logic [1:0]            gie_q;
    logic [7:0]            irqf_q;
    logic                  pa_lat_q;
    logic                  pa_dir_q;
    logic [2:0]            osc_q;
    logic                  pready_q;
    logic                  pslverr_q;
    logic [31:0]           prdata_q;
    logic [31:0]           rd_val;
    logic                  rd_hit;
    ri_pkg::ri_cls_t       cls;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event classes; power-on outranks other resets, which outrank wake-ups.
    wire ev_por  = i_por_rst | i_bor_rst;
    wire ev_rst  = i_master_clear_pin_reset | i_watchdog_timer_rst | i_sw_rst
                 | i_stack_full_rst | i_stack_unf_rst;
    wire ev_wake = i_watchdog_timer_wake | i_irq_wake;

    assign cls = ev_por  ? ri_pkg::RI_CLS_POR :
                 ev_rst  ? ri_pkg::RI_CLS_RST :
                 ev_wake ? ri_pkg::RI_CLS_WAKE : ri_pkg::RI_CLS_NONE;

    wire       irq_vec  = i_irq_wake & ~ev_por & ~ev_rst & (|gie_q);
    wire       cls_none = (cls == ri_pkg::RI_CLS_NONE);

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode; one wait-free access phase, writes land when pready is seen.
    wire       setup   = i_psel & ~i_penable;
    wire       wr_fire = i_psel & i_penable & i_pwrite & pready_q & ~pslverr_q;
    wire [5:0] widx    = i_paddr[7:2];
    wire [7:0] wbyte   = i_pwdata[7:0];

    wire       pa6_en  = PA6_IMPL
                       & ((osc_q == ri_pkg::RI_OSC_EXT_CLOCK_IO_OSC_MODE)
                       | (osc_q == ri_pkg::RI_OSC_RC_IO_OSC_MODE));

    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        if (widx < 6'(ri_pkg::RI_NREG)) begin
            if (widx == ri_pkg::RI_IDX_RESET_CAUSE_CONTROL) begin
                rd_val[7:0] = reset_cause_control_q;
            end else begin
                rd_val[7:0] = regs_q[widx[4:0]];
            end
        end else begin
            unique case (widx)
                ri_pkg::RI_IDX_PC:     rd_val[20:0] = pc_q;
                ri_pkg::RI_IDX_TOP:    rd_val[20:0] = top_q;
                ri_pkg::RI_IDX_SPTR:   rd_val[7:0]  = sptr_q;
                ri_pkg::RI_IDX_IRQC:   rd_val[7:6]  = gie_q;
                ri_pkg::RI_IDX_IRQF:   rd_val[7:0]  = irqf_q;
                ri_pkg::RI_IDX_PA_DAT: rd_val[6]    = pa6_en & i_port_a6;
                ri_pkg::RI_IDX_PA_LAT: rd_val[6]    = pa6_en & pa_lat_q;
                ri_pkg::RI_IDX_PA_DIR: rd_val[6]    = pa6_en & pa_dir_q;
                ri_pkg::RI_IDX_OSC:    rd_val[2:0]  = osc_q;
                default:               rd_hit       = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~rd_hit;
            if (setup) begin
                prdata_q <= rd_hit ? rd_val : 32'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Plain registers: reload or keep per class, else software write.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < ri_pkg::RI_NREG; i++) begin
                regs_q[i] <= ri_pkg::RI_POR_VAL[i] & ri_pkg::RI_MASK[i];
            end
        end else begin
            for (int i = 0; i < ri_pkg::RI_NREG; i++) begin
                unique case (cls)
                    ri_pkg::RI_CLS_POR: begin
                        regs_q[i] <= ri_pkg::RI_POR_VAL[i] & ri_pkg::RI_MASK[i];
                    end
                    ri_pkg::RI_CLS_RST: begin
                        if (ri_pkg::RI_RST_LOAD[i]) begin
                            regs_q[i] <= ri_pkg::RI_POR_VAL[i] & ri_pkg::RI_MASK[i];
                        end
                    end
                    ri_pkg::RI_CLS_WAKE: begin
                        if (ri_pkg::RI_WAKE_LOAD[i]) begin
                            regs_q[i] <= ri_pkg::RI_POR_VAL[i] & ri_pkg::RI_MASK[i];
                        end
                    end
                    ri_pkg::RI_CLS_NONE: begin
                        if (wr_fire && widx == 6'(i)) begin
                            regs_q[i] <= wbyte & ri_pkg::RI_MASK[i];
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset-cause flags follow the event that occurred.
    always_comb begin
        reset_cause_control_d = reset_cause_control_q;
        if (wr_fire && widx == ri_pkg::RI_IDX_RESET_CAUSE_CONTROL) begin
            reset_cause_control_d = wbyte & ri_pkg::RI_RESET_CAUSE_CONTROL_MASK;
        end
        if (i_por_rst) begin
            reset_cause_control_d = ri_pkg::RI_RESET_CAUSE_CONTROL_POR;
        end else if (i_bor_rst) begin
            reset_cause_control_d = {1'b0, reset_cause_control_q[6], 4'b0111, reset_cause_control_q[1], 1'b0};
        end else if (i_master_clear_pin_reset) begin
            reset_cause_control_d[7:6] = 2'b00;
            if (i_asleep) begin
                reset_cause_control_d[3:2] = 2'b10;
            end
        end else if (i_watchdog_timer_rst) begin
            reset_cause_control_d[ri_pkg::RI_RC_IPEN] = 1'b0;
            reset_cause_control_d[3:2] = 2'b01;
        end else if (i_sw_rst) begin
            reset_cause_control_d[ri_pkg::RI_RC_IPEN] = 1'b0;
            reset_cause_control_d[ri_pkg::RI_RC_RI]   = 1'b0;
        end else if (i_stack_full_rst || i_stack_unf_rst) begin
            reset_cause_control_d[ri_pkg::RI_RC_IPEN] = 1'b0;
        end else if (i_watchdog_timer_wake) begin
            reset_cause_control_d[3:2] = 2'b00;
        end else if (i_irq_wake) begin
            reset_cause_control_d[3:2] = 2'b10;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter and stack.
    always_comb begin
        pc_d   = pc_q;
        sptr_d = sptr_q;
        if (cls_none && wr_fire && widx == ri_pkg::RI_IDX_PC) begin
            pc_d = i_pwdata[20:0];
        end
        if (cls_none && wr_fire && widx == ri_pkg::RI_IDX_SPTR) begin
            sptr_d = wbyte & ri_pkg::RI_SPTR_MASK;
        end
        unique case (cls)
            ri_pkg::RI_CLS_POR: begin
                pc_d   = ri_pkg::RI_VEC_RESET;
                sptr_d = 8'h00;
            end
            ri_pkg::RI_CLS_RST: begin
                pc_d   = ri_pkg::RI_VEC_RESET;
                sptr_d = 8'h00;
                sptr_d[ri_pkg::RI_SP_FULL] = i_stack_full_rst;
                sptr_d[ri_pkg::RI_SP_UNF]  = i_stack_unf_rst;
            end
            ri_pkg::RI_CLS_WAKE: begin
                pc_d = pc_q + ri_pkg::RI_PC_STEP;
                if (irq_vec) begin
                    pc_d = gie_q[1] ? ri_pkg::RI_VEC_HIGH : ri_pkg::RI_VEC_LOW;
                    sptr_d[4:0] = sptr_q[4:0] + 5'h01;
                end
            end
            ri_pkg::RI_CLS_NONE: begin
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reset_cause_control_q <= ri_pkg::RI_RESET_CAUSE_CONTROL_POR;
            pc_q   <= ri_pkg::RI_VEC_RESET;
            sptr_q <= 8'h00;
            top_q  <= 21'h0;
        end else begin
            reset_cause_control_q <= reset_cause_control_d;
            pc_q   <= pc_d;
            sptr_q <= sptr_d;
            if (ev_por || ev_rst) begin
                top_q <= 21'h0;
            end else if (irq_vec) begin
                top_q <= pc_q;
            end else if (wr_fire && widx == ri_pkg::RI_IDX_TOP) begin
                top_q <= i_pwdata[20:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt enables and flags; a source that fires as software clears wins.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gie_q  <= 2'b00;
            irqf_q <= 8'h00;
        end else if (ev_por || ev_rst) begin
            gie_q  <= 2'b00;
            irqf_q <= 8'h00;
        end else begin
            if (wr_fire && widx == ri_pkg::RI_IDX_IRQC) begin
                gie_q <= {wbyte[ri_pkg::RI_IC_GLOBAL_IRQ_ENABLE_HIGH], wbyte[ri_pkg::RI_IC_GLOBAL_IRQ_ENABLE_LOW]};
            end
            if (wr_fire && widx == ri_pkg::RI_IDX_IRQF) begin
                irqf_q <= wbyte | i_irq_src;
            end else begin
                irqf_q <= irqf_q | i_irq_src;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port A bit 6 and the oscillator mode.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pa_lat_q <= 1'b0;
            pa_dir_q <= 1'b1;
            osc_q    <= ri_pkg::RI_OSC_RESET;
        end else if (ev_por) begin
            pa_lat_q <= 1'b0;
            pa_dir_q <= 1'b1;
            osc_q    <= ri_pkg::RI_OSC_RESET;
        end else if (ev_rst) begin
            pa_dir_q <= 1'b1;
        end else if (wr_fire) begin
            if (widx == ri_pkg::RI_IDX_PA_DAT || widx == ri_pkg::RI_IDX_PA_LAT) begin
                pa_lat_q <= wbyte[ri_pkg::RI_PA_BIT];
            end
            if (widx == ri_pkg::RI_IDX_PA_DIR) begin
                pa_dir_q <= wbyte[ri_pkg::RI_PA_BIT];
            end
            if (widx == ri_pkg::RI_IDX_OSC) begin
                osc_q <= wbyte[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs.
    always_ff @(posedge i_sys_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_port_a6_o  <= 1'b0;
            o_port_a6_oe <= 1'b0;
        end else begin
            o_port_a6_o  <= pa6_en & pa_lat_q;
            o_port_a6_oe <= pa6_en & ~pa_dir_q;
        end
    end

    assign o_prdata     = prdata_q;
    assign o_pready     = pready_q;
    assign o_pslverr    = pslverr_q;
    assign o_pc         = pc_q;
    assign o_long_wr_en = reset_cause_control_q[ri_pkg::RI_RC_LWRT];

endmodule

// File: core/ri_pkg.sv
package ri_pkg;

    localparam int          RI_NREG = 24;

    // Word indices; the byte address is four times the index.
    localparam logic [5:0]  RI_IDX_RESET_CAUSE_CONTROL   = 6'h0c;
    localparam logic [5:0]  RI_IDX_PC     = 6'h18;
    localparam logic [5:0]  RI_IDX_TOP    = 6'h19;
    localparam logic [5:0]  RI_IDX_SPTR   = 6'h1a;
    localparam logic [5:0]  RI_IDX_IRQC   = 6'h1b;
    localparam logic [5:0]  RI_IDX_IRQF   = 6'h1c;
    localparam logic [5:0]  RI_IDX_PA_DAT = 6'h1d;
    localparam logic [5:0]  RI_IDX_PA_LAT = 6'h1e;
    localparam logic [5:0]  RI_IDX_PA_DIR = 6'h1f;
    localparam logic [5:0]  RI_IDX_OSC    = 6'h20;

    // Plain registers: implemented bits, power-on value, reload on reset, reload on wake.
    localparam logic [7:0]  RI_MASK [RI_NREG] = '{
        8'h0f, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'h1f, 8'hff, 8'hff,
        8'hff, 8'h01, 8'h3f, 8'h01, 8'h00, 8'hff, 8'hff, 8'hbf,
        8'hff, 8'hff, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    localparam logic [7:0]  RI_POR_VAL [RI_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hff, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [23:0] RI_RST_LOAD  = 24'hf60f0d;
    localparam logic [23:0] RI_WAKE_LOAD = 24'h020000;

    // Reset-cause register.
    localparam logic [7:0]  RI_RESET_CAUSE_CONTROL_MASK = 8'hdf;
    localparam logic [7:0]  RI_RESET_CAUSE_CONTROL_POR  = 8'h1c;
    localparam int          RI_RC_LWRT   = 6;
    localparam int          RI_RC_IPEN   = 7;
    localparam int          RI_RC_RI     = 4;

    // Stack pointer layout.
    localparam logic [7:0]  RI_SPTR_MASK = 8'hdf;
    localparam int          RI_SP_FULL   = 7;
    localparam int          RI_SP_UNF    = 6;

    // Program counter values.
    localparam logic [20:0] RI_VEC_RESET = 21'h000000;
    localparam logic [20:0] RI_VEC_HIGH  = 21'h000008;
    localparam logic [20:0] RI_VEC_LOW   = 21'h000018;
    localparam logic [20:0] RI_PC_STEP   = 21'h000002;

    // Interrupt control bits and port A bit.
    localparam int          RI_IC_GLOBAL_IRQ_ENABLE_HIGH   = 7;
    localparam int          RI_IC_GLOBAL_IRQ_ENABLE_LOW   = 6;
    localparam int          RI_PA_BIT    = 6;
    localparam logic [2:0]  RI_OSC_RESET = 3'h7;

    typedef enum logic [2:0] {
        RI_OSC_LP    = 3'h0,
        RI_OSC_XT    = 3'h1,
        RI_OSC_HS    = 3'h2,
        RI_OSC_RC    = 3'h3,
        RI_OSC_EC    = 3'h4,
        RI_OSC_EXT_CLOCK_IO_OSC_MODE  = 3'h5,
        RI_OSC_HSPLL = 3'h6,
        RI_OSC_RC_IO_OSC_MODE  = 3'h7
    } ri_osc_t;

    typedef enum logic [3:0] {
        RI_CLS_NONE = 4'b0001,
        RI_CLS_POR  = 4'b0010,
        RI_CLS_RST  = 4'b0100,
        RI_CLS_WAKE = 4'b1000
    } ri_cls_t;

endpackage

// File: test/ri_reset_init_assertions.sv
`timescale 1ns/1ns
module ri_reset_init_assertions (
    // Clock, reset and bus.
    input wire logic        i_sys_clk,
    input wire logic        i_arst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // Events.
    input wire logic        i_por_rst,
    input wire logic        i_bor_rst,
    input wire logic        i_master_clear_pin_reset,
    input wire logic        i_watchdog_timer_rst,
    input wire logic        i_sw_rst,
    input wire logic        i_stack_full_rst,
    input wire logic        i_stack_unf_rst,
    input wire logic        i_watchdog_timer_wake,
    input wire logic        i_irq_wake,
    // Outputs.
    input wire logic [20:0] o_pc,
    input wire logic        o_long_wr_en
);
    wire soft_rst = i_watchdog_timer_rst | i_sw_rst | i_stack_full_rst | i_stack_unf_rst;
    wire any_rst  = soft_rst | i_por_rst | i_bor_rst | i_master_clear_pin_reset;
    wire apb_wr   = i_psel & i_penable & i_pwrite;

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);

    ////////////////////////////////////////////////////////////////////////////////
    property p_ready_after_setup; i_psel && !i_penable |=> o_pready; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("late ready");
    property p_ready_one; o_pready |=> !o_pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready too long");
    property p_err_with_ready; o_pslverr |-> o_pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("stray error");
    property p_rst_pc; any_rst |=> o_pc == 21'h0; endproperty
    a_rst_pc: assert property (p_rst_pc) else $error("pc not at reset vector");
    property p_wdt_wake_pc;
        i_watchdog_timer_wake && !any_rst && !i_irq_wake |=> o_pc == $past(o_pc) + 21'h2;
    endproperty
    a_wdt_wake_pc: assert property (p_wdt_wake_pc) else $error("wake pc wrong");
    property p_irq_wake_pc;
        i_irq_wake && !any_rst && !i_watchdog_timer_wake |=> o_pc == 21'h8
            || o_pc == 21'h18 || o_pc == $past(o_pc) + 21'h2;
    endproperty
    a_irq_wake_pc: assert property (p_irq_wake_pc) else $error("irq pc wrong");
    property p_lwen_clear; i_por_rst || i_master_clear_pin_reset |=> !o_long_wr_en; endproperty
    a_lwen_clear: assert property (p_lwen_clear) else $error("lwen not cleared");
    property p_lwen_keep;
        (soft_rst || i_bor_rst) && !i_por_rst && !i_master_clear_pin_reset && !apb_wr
            |=> $stable(o_long_wr_en);
    endproperty
    a_lwen_keep: assert property (p_lwen_keep) else $error("lwen changed");
    property p_pc_hold;
        !any_rst && !i_watchdog_timer_wake && !i_irq_wake && !apb_wr |=> $stable(o_pc);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved");
    c_irq: cover property (i_irq_wake ##1 o_pc == 21'h8);
    c_master_clear_pin_reset: cover property (i_master_clear_pin_reset);
    c_err: cover property (o_pslverr);
endmodule

bind ri_reset_init ri_reset_init_assertions u_chk (
    .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_por_rst(i_por_rst),
    .i_bor_rst(i_bor_rst), .i_master_clear_pin_reset(i_master_clear_pin_reset),
    .i_watchdog_timer_rst(i_watchdog_timer_rst), .i_sw_rst(i_sw_rst),
    .i_stack_full_rst(i_stack_full_rst), .i_stack_unf_rst(i_stack_unf_rst),
    .i_watchdog_timer_wake(i_watchdog_timer_wake), .i_irq_wake(i_irq_wake),
    .o_pc(o_pc), .o_long_wr_en(o_long_wr_en));

// File: test/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic        i_sys_clk;
    logic        i_arst_n;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic [8:0]  ev;
    logic        i_asleep;
    logic [7:0]  i_irq_src;
    logic        i_port_a6;
    logic [20:0] o_pc;
    logic        o_long_wr_en;
    logic        o_port_a6_o;
    logic        o_port_a6_oe;
    logic        nb_o;
    logic        nb_oe;
    logic [31:0] rdat;
    logic        rerr;
    logic [4:0]  sp;
    int          err_count;
    int          comparisons;
    int          cycles;

    ri_reset_init DUT (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_por_rst(ev[0]), .i_bor_rst(ev[1]),
        .i_master_clear_pin_reset(ev[2]), .i_watchdog_timer_rst(ev[3]), .i_sw_rst(ev[4]),
        .i_stack_full_rst(ev[5]), .i_stack_unf_rst(ev[6]), .i_watchdog_timer_wake(ev[7]),
        .i_irq_wake(ev[8]), .i_asleep(i_asleep), .i_irq_src(i_irq_src),
        .i_port_a6(i_port_a6), .o_pc(o_pc), .o_long_wr_en(o_long_wr_en),
        .o_port_a6_o(o_port_a6_o), .o_port_a6_oe(o_port_a6_oe));

    // Variant without port A bit 6; shares every input with DUT.
    ri_reset_init #(.PA6_IMPL(1'b0)) dut_no_pa6 (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(),
        .o_pready(), .o_pslverr(), .i_por_rst(ev[0]), .i_bor_rst(ev[1]),
        .i_master_clear_pin_reset(ev[2]), .i_watchdog_timer_rst(ev[3]), .i_sw_rst(ev[4]),
        .i_stack_full_rst(ev[5]), .i_stack_unf_rst(ev[6]), .i_watchdog_timer_wake(ev[7]),
        .i_irq_wake(ev[8]), .i_asleep(i_asleep), .i_irq_src(i_irq_src),
        .i_port_a6(i_port_a6), .o_pc(), .o_long_wr_en(),
        .o_port_a6_o(nb_o), .o_port_a6_oe(nb_oe));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("[FAIL] timeout expected finish seen %0d cycles", cycles);
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; waits for pready, and only the bench timeout ends a hang.
    task automatic apb(input logic w, input logic [5:0] ix, input logic [31:0] wd);
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= {ix, 2'b00};
        i_pwdata <= wd;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
        end while (o_pready !== 1'b1);
        rdat = o_prdata;
        rerr = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] ix, input string nm, input logic [31:0] e);
        apb(1'b0, ix, 32'h0);
        chk(nm, e, rdat);
    endtask

    // One-cycle event pulse; returns once the new values have landed.
    task automatic pulse(input int k);
        @(posedge i_sys_clk);
        ev <= 9'h1 << k;
        @(posedge i_sys_clk);
        ev <= 9'h0;
        @(posedge i_sys_clk);
    endtask

    initial begin
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {ev, i_asleep, i_irq_src, i_port_a6, cycles, err_count, comparisons} = '0;
        i_arst_n = 1'b0;
        repeat (10) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        rd(6'h08, "t0ctrl por", 32'hff);
        rd(6'h0a, "lvd por", 32'h05);
        rd(6'h11, "pr2 por", 32'hff);
        rd(6'h0c, "cause por", 32'h1c);
        for (int i = 0; i < ri_pkg::RI_NREG; i++) begin
            if (i == 12) continue;
            apb(1'b1, i[5:0], 32'hffff_ffff);
            apb(1'b0, i[5:0], 32'h0);
            chk("unused bits", 32'h0, rdat & ~{24'h0, ri_pkg::RI_MASK[i]});
        end
        apb(1'b0, 6'h3f, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        for (int k = 0; k < 7; k++) begin
            apb(1'b1, 6'h0c, 32'h40);
            apb(1'b1, 6'h08, 32'h00);
            apb(1'b1, 6'h01, 32'h5a);
            apb(1'b1, 6'h18, 32'h55);
            pulse(k);
            chk("reset pc", 32'h0, {11'h0, o_pc});
            chk("lwen", (k == 0 || k == 2) ? 32'h0 : 32'h1, {31'h0, o_long_wr_en});
            rd(6'h08, "t0ctrl", 32'hff);
            rd(6'h01, "ptr1 low", (k < 2) ? 32'h0 : 32'h5a);
            apb(1'b0, 6'h0c, 32'h0);
            if (k == 3) chk("wdt cause", 32'h1, {30'h0, rdat[3:2]});
            if (k == 4) chk("sw cause", 32'h0, {31'h0, rdat[4]});
            if (k >= 5) rd(6'h1a, "stack flag", (k == 5) ? 32'h80 : 32'h40);
        end
        i_asleep <= 1'b1;
        for (int g = 0; g < 3; g++) begin
            apb(1'b1, 6'h1b, (g == 0) ? 32'h80 : (g == 1) ? 32'h40 : 32'h0);
            apb(1'b1, 6'h18, 32'h1234);
            apb(1'b1, 6'h01, 32'ha5);
            apb(1'b0, 6'h1a, 32'h0);
            sp = rdat[4:0];
            i_irq_src <= 8'h04;
            pulse(8);
            i_irq_src <= 8'h00;
            chk("irq pc", (g == 0) ? 32'h8 : (g == 1) ? 32'h18 : 32'h1236, {11'h0, o_pc});
            if (g < 2) rd(6'h19, "stack top", 32'h1234);
            apb(1'b0, 6'h1a, 32'h0);
            chk("stack ptr", {27'h0, sp + ((g < 2) ? 5'h1 : 5'h0)}, {27'h0, rdat[4:0]});
            apb(1'b0, 6'h1c, 32'h0);
            chk("irq flag", 32'h4, rdat & 32'h4);
            apb(1'b0, 6'h0c, 32'h0);
            chk("irq cause", 32'h2, {30'h0, rdat[3:2]});
            rd(6'h01, "ptr1 wake", 32'ha5);
        end
        pulse(7);
        chk("wdt wake pc", 32'h1238, {11'h0, o_pc});
        apb(1'b0, 6'h0c, 32'h0);
        chk("wdt wake cause", 32'h0, {30'h0, rdat[3:2]});
        pulse(2);
        apb(1'b0, 6'h0c, 32'h0);
        chk("sleep clear cause", 32'h2, {30'h0, rdat[3:2]});
        i_port_a6 <= 1'b1;
        apb(1'b1, 6'h1e, 32'h40);
        apb(1'b1, 6'h1f, 32'h00);
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, 6'h20, m);
            rd(6'h1e, "latch b6", (m == 5 || m == 7) ? 32'h40 : 32'h0);
            chk("oe b6", (m == 5 || m == 7) ? 32'h1 : 32'h0, {31'h0, o_port_a6_oe});
            chk("out b6", (m == 5 || m == 7) ? 32'h1 : 32'h0, {31'h0, o_port_a6_o});
            rd(6'h1d, "pin b6", (m == 5 || m == 7) ? 32'h40 : 32'h0);
            chk("no b6 oe", 32'h0, {31'h0, nb_oe});
            chk("no b6 out", 32'h0, {31'h0, nb_o});
        end
        wrap_up();
    end
endmodule
